/* tcsc_bank.sv */
/*
 * status flags, sensor configuration, ema filter, alert compare and
 * burst counting of a thermocouple interface, behind a wishbone slave.
 * assumes conversion results and range levels arrive on CLK_SYS; the
 * short and open detector levels arrive asynchronously from pins.
 */
`timescale 1ns/1ps
module tcsc_bank #(
	parameter bit HAS_SHORT_DETECT = 1'b1
) (
	input  wire logic                     CLK_SYS,
	input  wire logic                     SYS_RST,
	input  wire logic                     WB_CYC_I,
	input  wire logic                     WB_STB_I,
	input  wire logic                     WB_WE_I,
	input  wire logic [7:0]               WB_ADR_I,
	input  wire logic [3:0]               WB_SEL_I,
	input  wire logic [31:0]              WB_DAT_I,
	output logic      [31:0]              WB_DAT_O,
	output logic                          WB_ACK_O,
	output logic                          IRQ,
	input  wire logic                     CONV_DONE,
	input  wire tcsc_pkg::tcsc_sample_type SAMPLE,
	input  wire logic                     EMF_OVER,
	input  wire logic                     SUM_OVER,
	input  wire logic                     BURST_MODE,
	input  wire logic [2:0]               BURST_SAMPLES,
	input  wire logic                     SHORT_PIN,
	input  wire logic                     OPEN_PIN,
	output logic [2:0]                    TC_TYPE,
	output logic                          SHUTDOWN_REQ
);
	tcsc_pkg::tcsc_state_type r;
	tcsc_pkg::tcsc_state_type next_r;
	logic [3:0]  alert_next;
	logic [7:0]  status_view;
	logic        wr_hit;
	logic        bus_req;
	logic [7:0]  wb_ofs;

	////////////////////////////////////////////////////////////////////
	// alert compare
	generate
		for (genvar i = 0; i < 4; i++) begin : g_alert
			logic signed [15:0] src;
			logic signed [15:0] lim;
			assign src = r.src_sel[i] ? r.cold : r.hot;
			assign lim = {r.limit[i], 2'b00};
			// hot source is the filtered value
			assign alert_next[i] = src > lim;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// status view
	// short bit gated by variant
	always_comb begin
		status_view = {r.burst_flag, r.conv_flag,
			r.short_flag & HAS_SHORT_DETECT, r.range_flag, r.alert};
	end

	assign bus_req = WB_CYC_I & WB_STB_I;
	assign wr_hit  = bus_req & WB_WE_I & r.ack & WB_SEL_I[0];
	assign wb_ofs  = WB_ADR_I;

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic signed [25:0] acc;
		logic signed [25:0] den;
		logic               in_range;
		logic               last;
		acc      = '0;
		den      = '0;
		in_range = 1'b0;
		last     = 1'b0;
		next_r   = r;

		// pin synchronisers, change counts when stages two and three agree
		next_r.short_sync = {r.short_sync[1:0], SHORT_PIN};
		next_r.open_sync  = {r.open_sync[1:0], OPEN_PIN};
		if (r.short_sync[1] == r.short_sync[2]) begin
			next_r.short_flag = r.short_sync[2];
		end
		if (r.open_sync[1] == r.open_sync[2]) begin
			next_r.open_flag = r.open_sync[2];
		end

		// range from input voltage or hot result
		// open input also flags range on short-detect variant
		next_r.range_flag = EMF_OVER | SUM_OVER
			| (r.open_flag & HAS_SHORT_DETECT);
		next_r.alert = alert_next;

		next_r.conv_flag = CONV_DONE | (r.conv_flag
			& ~(wr_hit && wb_ofs == tcsc_pkg::OFS_STATUS
			&& WB_DAT_I[tcsc_pkg::BIT_CONV]));
		next_r.burst_flag = r.burst_flag
			& ~(wr_hit && wb_ofs == tcsc_pkg::OFS_STATUS
			&& WB_DAT_I[tcsc_pkg::BIT_BURST]);

		// count samples of a burst, then request shutdown
		last = r.burst_cnt == 8'((9'h001 << BURST_SAMPLES) - 9'h001);
		if (!BURST_MODE) begin
			next_r.burst_cnt = '0;
			next_r.shut      = 1'b0;
		end else if (CONV_DONE && !r.shut) begin
			next_r.burst_cnt = last ? 8'h00 : r.burst_cnt + 8'h01;
			if (last) begin
				next_r.shut = 1'b1;
				next_r.burst_flag = 1'b1;
			end
		end

		// conversion results
		if (CONV_DONE) begin
			in_range = !EMF_OVER && !SUM_OVER;
			next_r.cold = SAMPLE.cold;
			// delta updates while input voltage is in range
			if (!EMF_OVER) begin
				next_r.delta = SAMPLE.delta;
			end
			if (in_range) begin
				next_r.primed = 1'b1;
				// first sample after reset loads directly
				if (r.coef == 3'h0 || !r.primed) begin
					next_r.hot = SAMPLE.hot;
				end else begin
					// y = (2x + (2^n-1)y1) / (2^n+1)
					den = 26'(26'sd1 <<< r.coef);
					acc = 26'(2 * $signed(SAMPLE.hot))
						+ 26'((den - 26'sd1) * $signed(r.hot));
					acc = acc / (den + 26'sd1);
					next_r.hot = acc[15:0];
				end
			end
		end

		// register writes
		if (wr_hit) begin
			unique case (wb_ofs)
				tcsc_pkg::OFS_CONFIG: begin
					next_r.tc_type = WB_DAT_I[tcsc_pkg::POS_TYPE +: 3];
					next_r.coef    = WB_DAT_I[tcsc_pkg::POS_COEF +: 3];
					next_r.primed  = 1'b0;
				end
				tcsc_pkg::OFS_MASK: begin
					next_r.mask = WB_DAT_I[7:0];
				end
				tcsc_pkg::OFS_SRC_SEL: begin
					next_r.src_sel = WB_DAT_I[3:0];
				end
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (wb_ofs == tcsc_pkg::OFS_LIMIT0 + 8'(4 * i)
							&& WB_SEL_I[1]) begin
							next_r.limit[i] = WB_DAT_I[15:2];
						end
					end
				end
			endcase
		end

		// answer one cycle after the request is seen
		next_r.ack = bus_req & ~r.ack;
		if (bus_req && !r.ack) begin
			next_r.dat = '0;
			unique case (wb_ofs)
				tcsc_pkg::OFS_STATUS: next_r.dat[7:0] = status_view;
				// bits 7 and 3 read zero
				tcsc_pkg::OFS_CONFIG: next_r.dat[7:0] =
					{1'b0, r.tc_type, 1'b0, r.coef};
				tcsc_pkg::OFS_MASK:    next_r.dat[7:0]  = r.mask;
				tcsc_pkg::OFS_HOT:     next_r.dat[15:0] = r.hot;
				tcsc_pkg::OFS_DELTA:   next_r.dat[15:0] = r.delta;
				tcsc_pkg::OFS_COLD:    next_r.dat[15:0] = r.cold;
				tcsc_pkg::OFS_SRC_SEL: next_r.dat[3:0]  = r.src_sel;
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (wb_ofs == tcsc_pkg::OFS_LIMIT0 + 8'(4 * i)) begin
							next_r.dat[15:0] = {r.limit[i], 2'b00};
						end
					end
				end
			endcase
		end

		next_r.irq = |(status_view & r.mask);
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			r            <= '0;
			r.tc_type    <= tcsc_pkg::RST_TYPE;
			r.coef       <= tcsc_pkg::RST_COEF;
			r.mask       <= tcsc_pkg::RST_MASK;
			r.hot        <= tcsc_pkg::RST_TEMP;
			r.delta      <= tcsc_pkg::RST_TEMP;
			r.cold       <= tcsc_pkg::RST_TEMP;
			r.limit      <= {4{tcsc_pkg::RST_LIMIT}};
		end else begin
			r <= next_r;
		end
	end

	assign WB_DAT_O     = r.dat;
	assign WB_ACK_O     = r.ack;
	assign IRQ          = r.irq;
	assign TC_TYPE      = r.tc_type;
	assign SHUTDOWN_REQ = r.shut;

	////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	a_burst_flag_set: assert property (
		BURST_MODE && CONV_DONE && !r.shut
			&& r.burst_cnt == 8'((9'h001 << BURST_SAMPLES) - 9'h001)
		|=> r.burst_flag && SHUTDOWN_REQ)
		else $error("burst end did not set flag");
	a_conv_flag_set: assert property (
		CONV_DONE |=> r.conv_flag)
		else $error("conversion did not set update flag");
	a_short_bit_zero: assert property (
		!HAS_SHORT_DETECT |-> !status_view[tcsc_pkg::BIT_SHORT])
		else $error("short bit set on variant without detection");
	a_range_follow: assert property (
		EMF_OVER |=> status_view[tcsc_pkg::BIT_RANGE])
		else $error("range flag missed input over range");
	a_emf_hold: assert property (
		CONV_DONE && EMF_OVER && !wr_hit
		|=> $stable(r.hot) && $stable(r.delta)
			&& r.cold == $past(SAMPLE.cold))
		else $error("out of range conversion changed hot or delta");
	a_sum_hold: assert property (
		CONV_DONE && !EMF_OVER && SUM_OVER
		|=> $stable(r.hot) && r.delta == $past(SAMPLE.delta))
		else $error("sum over range handled wrongly");
	a_alert_cmp: assert property (
		##1 r.alert[0] == ($past(r.src_sel[0]) ?
			$signed($past(r.cold)) > $signed({$past(r.limit[0]), 2'b00}) :
			$signed($past(r.hot)) > $signed({$past(r.limit[0]), 2'b00})))
		else $error("alert one flag disagrees with compare");
	a_cfg_zero_bits: assert property (
		bus_req && !r.ack && wb_ofs == tcsc_pkg::OFS_CONFIG
		|=> WB_ACK_O && !WB_DAT_O[7] && !WB_DAT_O[3])
		else $error("unimplemented config bits read nonzero");
	a_cfg_resets_filt: assert property (
		wr_hit && wb_ofs == tcsc_pkg::OFS_CONFIG |=> !r.primed)
		else $error("config write left filter primed");
	a_first_load: assert property (
		CONV_DONE && !EMF_OVER && !SUM_OVER && (!r.primed || r.coef == 3'h0)
		|=> r.hot == $past(SAMPLE.hot))
		else $error("first sample not loaded directly");
	a_clear_loses: assert property (
		CONV_DONE && wr_hit && wb_ofs == tcsc_pkg::OFS_STATUS
		|=> r.conv_flag)
		else $error("clear won over conversion");

	generate
		for (genvar i = 1; i < 4; i++) begin : g_alert_chk
			a_alert_each: assert property (
				##1 r.alert[i] == (($past(r.src_sel[i])
					? $signed($past(r.cold)) : $signed($past(r.hot)))
					> $signed({$past(r.limit[i]), 2'b00})))
				else $error("alert flag disagrees with compare");
		end
	endgenerate

	a_type_store: assert property (
		wr_hit && wb_ofs == tcsc_pkg::OFS_CONFIG
		|=> TC_TYPE == $past(WB_DAT_I[tcsc_pkg::POS_TYPE +: 3]))
		else $error("type select not stored");
	a_coef_store: assert property (
		wr_hit && wb_ofs == tcsc_pkg::OFS_CONFIG
		|=> r.coef == $past(WB_DAT_I[tcsc_pkg::POS_COEF +: 3]))
		else $error("filter coefficient not stored");
	a_coef_zero_pass: assert property (
		CONV_DONE && !EMF_OVER && !SUM_OVER && r.coef == 3'h0
		|=> r.hot == $past(SAMPLE.hot))
		else $error("filter off but sample not passed through");
	a_filter_step: assert property (
		CONV_DONE && !EMF_OVER && !SUM_OVER && r.primed && r.coef == 3'h1
		|=> r.hot == 16'((2 * $signed($past(SAMPLE.hot))
			+ $signed($past(r.hot))) / 3))
		else $error("filter step with n of one is wrong");
	a_conv_clear: assert property (
		wr_hit && wb_ofs == tcsc_pkg::OFS_STATUS
			&& WB_DAT_I[tcsc_pkg::BIT_CONV] && !CONV_DONE
		|=> !r.conv_flag)
		else $error("update flag not cleared by write one");
	a_short_follow: assert property (
		r.short_flag |-> status_view[tcsc_pkg::BIT_SHORT] == HAS_SHORT_DETECT)
		else $error("short bit does not follow synchronised pin");
	a_range_clear: assert property (
		!EMF_OVER && !SUM_OVER && !(HAS_SHORT_DETECT && r.open_flag)
		|=> !status_view[tcsc_pkg::BIT_RANGE])
		else $error("range flag set while input in range");
	a_open_range: assert property (
		HAS_SHORT_DETECT && r.open_flag |=> status_view[tcsc_pkg::BIT_RANGE])
		else $error("open input did not raise range flag");
	a_burst_idle: assert property (
		!BURST_MODE |=> !SHUTDOWN_REQ)
		else $error("shutdown requested outside burst mode");
	a_burst_hold: assert property (
		SHUTDOWN_REQ && BURST_MODE |=> SHUTDOWN_REQ)
		else $error("shutdown request dropped during burst mode");
	a_burst_early: assert property (
		BURST_MODE && CONV_DONE && !r.shut && r.burst_cnt == 8'h00
			&& BURST_SAMPLES != 3'h0
		|=> !SHUTDOWN_REQ)
		else $error("burst ended before its sample count");

	c_burst_done: cover property (BURST_MODE ##[1:200] SHUTDOWN_REQ);
	c_filtered: cover property (CONV_DONE && r.primed && r.coef != 3'h0);
	c_cfg_write: cover property (wr_hit && wb_ofs == tcsc_pkg::OFS_CONFIG);
	c_irq: cover property (IRQ);
	c_clear_race: cover property (CONV_DONE && wr_hit
		&& wb_ofs == tcsc_pkg::OFS_STATUS);
endmodule

/* tcsc_bank_bench.sv */
/*
 * self-checking bench of the thermocouple status and config bank.
 * assumes one clock, a classic wishbone slave and no partner model.
 */
`timescale 1ns/1ps
module tcsc_bank_bench;
	logic                      clk_sys;
	logic                      sys_rst;
	logic                      cyc;
	logic                      we;
	logic [7:0]                adr;
	logic [31:0]               wdat;
	logic [3:0]                sel;
	logic [31:0]               q_dump;
	logic [31:0]               rdat;
	logic                      ack;
	logic                      irq;
	logic                      conv_done;
	tcsc_pkg::tcsc_sample_type samp;
	logic                      emf_over;
	logic                      sum_over;
	logic                      burst_mode;
	logic [2:0]                burst_samples;
	logic                      short_pin;
	logic                      open_pin;
	logic [2:0]                tc_type;
	logic                      shutdown_req;
	int                        bad_count = 0;
	int                        samples_checked = 0;
	int                        cycles = 0;

	tcsc_bank tcsc_bank_inst (
		.CLK_SYS       (clk_sys),
		.SYS_RST       (sys_rst),
		.WB_CYC_I      (cyc),
		.WB_STB_I      (cyc),
		.WB_WE_I       (we),
		.WB_ADR_I      (adr),
		.WB_SEL_I      (sel),
		.WB_DAT_I      (wdat),
		.WB_DAT_O      (rdat),
		.WB_ACK_O      (ack),
		.IRQ           (irq),
		.CONV_DONE     (conv_done),
		.SAMPLE        (samp),
		.EMF_OVER      (emf_over),
		.SUM_OVER      (sum_over),
		.BURST_MODE    (burst_mode),
		.BURST_SAMPLES (burst_samples),
		.SHORT_PIN     (short_pin),
		.OPEN_PIN      (open_pin),
		.TC_TYPE       (tc_type),
		.SHUTDOWN_REQ  (shutdown_req)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] m, output logic [31:0] q);
		@(posedge clk_sys);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= m;
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hF, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, 4'hF, q);
		chk(q, e);
	endtask

	task automatic conv(input logic [15:0] h, input logic [15:0] dl,
		input logic [15:0] c, input logic e, input logic s);
		@(posedge clk_sys);
		conv_done <= 1'b1;
		samp      <= {h, dl, c};
		emf_over  <= e;
		sum_over  <= s;
		@(posedge clk_sys);
		conv_done <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		sys_rst = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		sel = 4'h0;
		conv_done = 1'b0;
		samp = '0;
		emf_over = 1'b0;
		sum_over = 1'b0;
		burst_mode = 1'b0;
		burst_samples = 3'h0;
		short_pin = 1'b0;
		open_pin = 1'b0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_0000);
		rd(tcsc_pkg::OFS_CONFIG, 32'h0000_0000);
		rd(8'hFC, 32'h0000_0000);
		for (int t = 0; t < 8; t++) begin
			wr(tcsc_pkg::OFS_CONFIG, 32'(t) << 4);
			rd(tcsc_pkg::OFS_CONFIG, 32'(t) << 4);
			chk(32'(tc_type), 32'(t));
		end
		wr(tcsc_pkg::OFS_CONFIG, 32'h0000_00FF);
		rd(tcsc_pkg::OFS_CONFIG, 32'h0000_0077);
		wr(tcsc_pkg::OFS_CONFIG, 32'h0000_0000);
		wr(tcsc_pkg::OFS_MASK, 32'h0000_0040);
		wb(1'b1, tcsc_pkg::OFS_MASK, 32'h0000_00FF, 4'h0, q_dump);
		rd(tcsc_pkg::OFS_MASK, 32'h0000_0040);
		conv(16'h0100, 16'h0050, 16'h0020, 1'b0, 1'b0);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_004F);
		chk(32'(irq), 32'h0000_0001);
		rd(tcsc_pkg::OFS_HOT, 32'h0000_0100);
		rd(tcsc_pkg::OFS_DELTA, 32'h0000_0050);
		rd(tcsc_pkg::OFS_COLD, 32'h0000_0020);
		wr(tcsc_pkg::OFS_LIMIT0, 32'h0000_0100);
		wr(tcsc_pkg::OFS_LIMIT0 + 8'h04, 32'h0000_00FC);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_004E);
		wr(tcsc_pkg::OFS_SRC_SEL, 32'h0000_0002);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_004C);
		wr(tcsc_pkg::OFS_STATUS, 32'h0000_0000);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_004C);
		wr(tcsc_pkg::OFS_STATUS, 32'h0000_00FF);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_000C);
		chk(32'(irq), 32'h0000_0000);
		conv(16'h0200, 16'h0060, 16'h0030, 1'b1, 1'b0);
		rd(tcsc_pkg::OFS_HOT, 32'h0000_0100);
		rd(tcsc_pkg::OFS_DELTA, 32'h0000_0050);
		rd(tcsc_pkg::OFS_COLD, 32'h0000_0030);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_005C);
		conv(16'h0200, 16'h0060, 16'h0040, 1'b0, 1'b1);
		rd(tcsc_pkg::OFS_HOT, 32'h0000_0100);
		rd(tcsc_pkg::OFS_DELTA, 32'h0000_0060);
		rd(tcsc_pkg::OFS_COLD, 32'h0000_0040);
		wr(tcsc_pkg::OFS_CONFIG, 32'h0000_0001);
		conv(16'h0300, 16'h0000, 16'h0000, 1'b0, 1'b0);
		rd(tcsc_pkg::OFS_HOT, 32'h0000_0300);
		conv(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		rd(tcsc_pkg::OFS_HOT, 32'h0000_0100);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_004C);
		wr(tcsc_pkg::OFS_CONFIG, 32'h0000_0001);
		conv(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		rd(tcsc_pkg::OFS_HOT, 32'h0000_0000);
		fork
			wr(tcsc_pkg::OFS_STATUS, 32'h0000_00FF);
			begin
				@(posedge clk_sys);
				conv(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
			end
		join
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_0040);
		wr(tcsc_pkg::OFS_STATUS, 32'h0000_00FF);
		@(posedge clk_sys);
		burst_samples <= 3'h1;
		burst_mode <= 1'b1;
		conv(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_0040);
		chk(32'(shutdown_req), 32'h0000_0000);
		conv(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_00C0);
		chk(32'(shutdown_req), 32'h0000_0001);
		short_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_00E0);
		open_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(tcsc_pkg::OFS_STATUS, 32'h0000_00F0);
		wr(tcsc_pkg::OFS_MASK, 32'h0000_0000);
		repeat (2) @(negedge clk_sys);
		chk(32'(irq), 32'h0000_0000);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(tcsc_pkg::OFS_CONFIG, 32'h0000_0000);
		rd(tcsc_pkg::OFS_LIMIT0, 32'h0000_0000);
		summarize();
	end
endmodule

/* tcsc_pkg.sv */
/*
 * shared constants and types of the thermocouple status/config bank.
 * assumes one system clock and a classic wishbone master with 32-bit data.
 */
package tcsc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_STATUS  = 8'h00;
	localparam logic [7:0] OFS_CONFIG  = 8'h04;
	localparam logic [7:0] OFS_MASK    = 8'h08;
	localparam logic [7:0] OFS_HOT     = 8'h0C;
	localparam logic [7:0] OFS_DELTA   = 8'h10;
	localparam logic [7:0] OFS_COLD    = 8'h14;
	localparam logic [7:0] OFS_SRC_SEL = 8'h18;
	localparam logic [7:0] OFS_LIMIT0  = 8'h1C;
	// status field positions
	localparam int BIT_BURST = 7;
	localparam int BIT_CONV  = 6;
	localparam int BIT_SHORT = 5;
	localparam int BIT_RANGE = 4;
	// config field positions
	localparam int POS_TYPE = 4;
	localparam int POS_COEF = 0;
	// reset values
	localparam logic [2:0]  RST_TYPE  = 3'h0;
	localparam logic [2:0]  RST_COEF  = 3'h0;
	localparam logic [7:0]  RST_MASK  = 8'h00;
	localparam logic [15:0] RST_TEMP  = 16'h0000;
	localparam logic [13:0] RST_LIMIT = 14'h0000;

	typedef struct packed {
		logic [15:0] hot;
		logic [15:0] delta;
		logic [15:0] cold;
	} tcsc_sample_type;

	typedef struct packed {
		logic [2:0]        tc_type;
		logic [2:0]        coef;
		logic              burst_flag;
		logic              conv_flag;
		logic              range_flag;
		logic [3:0]        alert;
		logic [7:0]        mask;
		logic [15:0]       hot;
		logic [15:0]       delta;
		logic [15:0]       cold;
		logic              primed;
		logic [3:0]        src_sel;
		logic [3:0][13:0]  limit;
		logic [7:0]        burst_cnt;
		logic              shut;
		logic [2:0]        short_sync;
		logic [2:0]        open_sync;
		logic              short_flag;
		logic              open_flag;
		logic              ack;
		logic [31:0]       dat;
		logic              irq;
	} tcsc_state_type;
endpackage
